//--- hw/lcdcd_pkg.sv
// Constants for the segment LCD command decoder.
// Assumes a single synchronous clock domain; shared by all design files.
package lcdcd_pkg;
	// Geometry of the display RAM and reset values of the address registers.
	localparam int PAGES = 4;
	localparam int COLUMNS = 80;
	localparam logic [6:0] COL_LIMIT = 7'h50;
	localparam logic [6:0] COL_RESET = 7'h00;
	localparam logic [1:0] PAGE_RESET = 2'h3;
	localparam logic [4:0] LINE_RESET = 5'h00;
	// Command encodings.
	localparam logic [6:0] CMD_DISP_HI = 7'h57;
	localparam logic [6:0] CMD_ORDER_HI = 7'h50;
	localparam logic [6:0] CMD_STATIC_HI = 7'h52;
	localparam logic [6:0] CMD_DUTY_HI = 7'h54;
	localparam logic [2:0] CMD_LINE_HI = 3'h6;
	localparam logic [5:0] CMD_PAGE_HI = 6'h2E;
	localparam logic [7:0] CMD_RMW = 8'hE0;
	localparam logic [7:0] CMD_END = 8'hEE;
	localparam logic [7:0] CMD_SWRESET = 8'hE2;
	// Status byte bit positions.
	localparam int ST_BUSY = 7;
	localparam int ST_ORDER = 6;
	localparam int ST_OFF = 5;
	localparam int ST_RESET = 4;
	// Cycles the soft reset keeps the busy and reset flags up.
	localparam logic [3:0] RESET_CYCLES = 4'h4;
endpackage

//--- hw/lcdcd_ram.sv
// Display data RAM, one byte per page and column.
// Assumes a synchronous write and registered read in the same clock.
`timescale 1ns/1ps
module lcdcd_ram #(
	parameter int PAGES = lcdcd_pkg::PAGES,
	parameter int COLUMNS = lcdcd_pkg::COLUMNS
) (
	// Clock.
	input wire logic clk,
	// Access port.
	input wire logic [1:0] page,
	input wire logic [6:0] column,
	input wire logic wr_en,
	input wire logic [7:0] wr_data,
	output logic [7:0] rd_data
);
	logic [7:0] mem [PAGES*COLUMNS];
	wire logic [8:0] addr = 9'(page) * 9'(COLUMNS) + 9'(column);
	wire logic in_range = column < 7'(COLUMNS);

	// Writes past the last column are dropped rather than wrapping.
	always_ff @(posedge clk) begin
		if (wr_en && in_range) begin
			mem[addr] <= wr_data;
		end
		rd_data <= in_range ? mem[addr] : 8'h00;
	end
endmodule

//--- hw/lcdcd_top.sv
// Command decoder of a segment LCD driver with on-chip display RAM.
// Assumes host strobes are synchronous, one clock wide per access.
`timescale 1ns/1ps
module lcdcd_top (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset,
	// Host bus.
	input wire logic cmd_data_select,
	input wire logic rd_strobe,
	input wire logic wr_strobe,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe,
	// Display state.
	output logic display_on,
	output logic [4:0] first_common_row,
	output logic reversed_segment_order,
	output logic static_drive,
	output logic duty_32,
	output logic rmw_active
);
	logic [4:0] first_row_pointer_reg;
	logic [1:0] page_select_reg;
	logic [6:0] column_pointer_reg;
	logic [6:0] saved_column_reg;
	logic [3:0] reset_count_reg;
	logic [7:0] io_latch_reg;
	logic [7:0] data_out_reg;
	logic data_oe_reg;
	logic disp_reg;
	logic order_reg;
	logic static_reg;
	logic duty_reg;
	logic rmw_reg;
	logic [7:0] ram_rd;

	// Access decode.
	wire logic resetting = reset_count_reg != 4'h0;
	wire logic busy = resetting;
	wire logic cmd_wr = !cmd_data_select && wr_strobe && !busy;
	wire logic stat_rd = !cmd_data_select && rd_strobe;
	wire logic dat_wr = cmd_data_select && wr_strobe && !busy;
	wire logic dat_rd = cmd_data_select && rd_strobe && !busy;

	// Command decode.
	wire logic c_disp = cmd_wr && data_in[7:1] == lcdcd_pkg::CMD_DISP_HI;
	wire logic c_order = cmd_wr && data_in[7:1] == lcdcd_pkg::CMD_ORDER_HI;
	wire logic c_static = cmd_wr && data_in[7:1] == lcdcd_pkg::CMD_STATIC_HI;
	wire logic c_duty = cmd_wr && data_in[7:1] == lcdcd_pkg::CMD_DUTY_HI;
	wire logic c_line = cmd_wr && data_in[7:5] == lcdcd_pkg::CMD_LINE_HI;
	wire logic c_page = cmd_wr && data_in[7:2] == lcdcd_pkg::CMD_PAGE_HI;
	// Column set is ignored in read-modify-write so the saved one survives.
	wire logic c_col = cmd_wr && !data_in[7] && !rmw_reg;
	wire logic c_rmw = cmd_wr && data_in == lcdcd_pkg::CMD_RMW;
	wire logic c_end = cmd_wr && data_in == lcdcd_pkg::CMD_END;
	wire logic c_swr = cmd_wr && data_in == lcdcd_pkg::CMD_SWRESET;
	// No decode matched, so the byte must leave every register alone.
	wire logic c_none = cmd_wr && !(c_disp || c_order || c_static || c_duty
		|| c_line || c_page || c_col || c_rmw || c_end || c_swr);

	// Auto-increment; reads in read-modify-write leave the column alone.
	wire logic col_step = (dat_wr || (dat_rd && !rmw_reg))
		&& column_pointer_reg < lcdcd_pkg::COL_LIMIT;
	wire logic [6:0] column_next = c_col ? data_in[6:0] :
		(c_end && rmw_reg) ? saved_column_reg :
		col_step ? column_pointer_reg + 7'h01 : column_pointer_reg;

	wire logic [7:0] status_byte = {busy, !order_reg, !disp_reg,
		resetting, 4'h0};

	lcdcd_ram u_ram (
		.clk(clk),
		.page(page_select_reg),
		.column(column_pointer_reg),
		.wr_en(dat_wr),
		.wr_data(data_in),
		.rd_data(ram_rd)
	);

	// Mode flags.
	always_ff @(posedge clk) begin
		if (reset) begin
			disp_reg <= 1'b0;
			order_reg <= 1'b0;
			static_reg <= 1'b0;
			duty_reg <= 1'b1;
		end else begin
			if (c_disp) disp_reg <= data_in[0];
			if (c_order) order_reg <= data_in[0];
			if (c_static) static_reg <= data_in[0];
			if (c_duty) duty_reg <= data_in[0];
		end
	end

	// Address registers; unmatched codes fall through unchanged.
	always_ff @(posedge clk) begin
		if (reset) begin
			first_row_pointer_reg <= lcdcd_pkg::LINE_RESET;
			page_select_reg <= lcdcd_pkg::PAGE_RESET;
			column_pointer_reg <= lcdcd_pkg::COL_RESET;
			saved_column_reg <= lcdcd_pkg::COL_RESET;
			rmw_reg <= 1'b0;
		end else begin
			if (c_line) first_row_pointer_reg <= data_in[4:0];
			if (c_swr) first_row_pointer_reg <= lcdcd_pkg::LINE_RESET;
			if (c_page) page_select_reg <= data_in[1:0];
			if (c_swr) page_select_reg <= lcdcd_pkg::PAGE_RESET;
			column_pointer_reg <= column_next;
			if (c_rmw) begin
				rmw_reg <= 1'b1;
				saved_column_reg <= column_pointer_reg;
			end
			if (c_end) rmw_reg <= 1'b0;
		end
	end

	// Reset progress counter for hardware and soft reset.
	always_ff @(posedge clk) begin
		if (reset) begin
			reset_count_reg <= lcdcd_pkg::RESET_CYCLES;
		end else if (c_swr) begin
			reset_count_reg <= lcdcd_pkg::RESET_CYCLES;
		end else if (resetting) begin
			reset_count_reg <= reset_count_reg - 4'h1;
		end
	end

	// Read path: a data read returns the latch, then refills it.
	always_ff @(posedge clk) begin
		if (reset) begin
			io_latch_reg <= 8'h00;
			data_out_reg <= 8'h00;
			data_oe_reg <= 1'b0;
		end else begin
			data_oe_reg <= stat_rd || dat_rd;
			if (stat_rd) data_out_reg <= status_byte;
			else if (dat_rd) data_out_reg <= io_latch_reg;
			if (dat_rd) io_latch_reg <= ram_rd;
		end
	end

	assign data_out = data_out_reg;
	assign data_oe = data_oe_reg;
	assign display_on = disp_reg;
	assign first_common_row = first_row_pointer_reg;
	assign reversed_segment_order = order_reg;
	assign static_drive = static_reg;
	assign duty_32 = duty_reg;
	assign rmw_active = rmw_reg;

	// Checks. Read-modify-write and the reset run span several edges,
	// so their steps are written out as named sequences.
	sequence s_rmw_enter;
		c_rmw;
	endsequence

	sequence s_rmw_leave;
		c_end && rmw_reg;
	endsequence

	// The repeat count must follow RESET_CYCLES by hand.
	sequence s_reset_run;
		resetting [*4] ##1 !resetting;
	endsequence

	// Mode commands.
	a_disp_follows_cmd: assert property (
		@(posedge clk) disable iff (reset)
		c_disp |=> display_on == $past(data_in[0]))
		else $error("display enable did not follow command");
	a_order_load: assert property (
		@(posedge clk) disable iff (reset)
		c_order |=> reversed_segment_order == $past(data_in[0]))
		else $error("segment order not loaded");
	a_static_load: assert property (
		@(posedge clk) disable iff (reset)
		c_static |=> static_drive == $past(data_in[0]))
		else $error("static drive not loaded");
	a_duty_load: assert property (
		@(posedge clk) disable iff (reset)
		c_duty |=> duty_32 == $past(data_in[0]))
		else $error("duty select not loaded");
	a_page_display: assert property (
		@(posedge clk) disable iff (reset)
		c_page |=> $stable({display_on, first_common_row,
		static_drive, duty_32, reversed_segment_order}))
		else $error("page change altered the display");

	// Address registers.
	a_line_load: assert property (
		@(posedge clk) disable iff (reset)
		c_line && !c_swr |=> first_common_row == $past(data_in[4:0]))
		else $error("start line not loaded");
	a_page_load: assert property (
		@(posedge clk) disable iff (reset)
		c_page |=> page_select_reg == $past(data_in[1:0]))
		else $error("page not loaded");
	a_page_hold: assert property (
		@(posedge clk) disable iff (reset)
		!c_page && !c_swr |=> $stable(page_select_reg))
		else $error("page moved without a command");
	a_col_load: assert property (
		@(posedge clk) disable iff (reset)
		c_col |=> column_pointer_reg == $past(data_in[6:0]))
		else $error("column not loaded");
	a_col_step: assert property (
		@(posedge clk) disable iff (reset)
		dat_wr && !c_col && column_pointer_reg < lcdcd_pkg::COL_LIMIT
		|=> column_pointer_reg == $past(column_pointer_reg) + 7'h01)
		else $error("column did not step");
	a_col_read_step: assert property (
		@(posedge clk) disable iff (reset)
		dat_rd && !rmw_reg && column_pointer_reg < lcdcd_pkg::COL_LIMIT
		|=> column_pointer_reg == $past(column_pointer_reg) + 7'h01)
		else $error("column did not step on read");
	a_col_limit: assert property (
		@(posedge clk) disable iff (reset)
		column_pointer_reg == lcdcd_pkg::COL_LIMIT && !c_col && !c_end
		|=> column_pointer_reg == lcdcd_pkg::COL_LIMIT)
		else $error("column passed its limit");
	a_unknown_keep: assert property (
		@(posedge clk) disable iff (reset)
		c_none |=> $stable({disp_reg, order_reg, static_reg, duty_reg,
		first_row_pointer_reg, page_select_reg, column_pointer_reg,
		saved_column_reg, rmw_reg}))
		else $error("unknown command changed state");

	// Read-modify-write.
	a_rmw_save: assert property (
		@(posedge clk) disable iff (reset)
		s_rmw_enter |=> rmw_active
		&& saved_column_reg == $past(column_pointer_reg))
		else $error("column not saved on entry");
	a_rmw_read_hold: assert property (
		@(posedge clk) disable iff (reset)
		dat_rd && rmw_reg |=> $stable(column_pointer_reg))
		else $error("column stepped on a held read");
	a_rmw_restore: assert property (
		@(posedge clk) disable iff (reset)
		s_rmw_leave |=> !rmw_active
		&& column_pointer_reg == $past(saved_column_reg))
		else $error("column not restored");

	// Busy and reset.
	a_busy_blocks: assert property (
		@(posedge clk) disable iff (reset)
		busy && cmd_data_select && wr_strobe
		|=> $stable(column_pointer_reg))
		else $error("access taken while busy");
	a_busy_cmd: assert property (
		@(posedge clk) disable iff (reset)
		busy && !cmd_data_select && wr_strobe
		|=> $stable({display_on, first_common_row, rmw_active,
		page_select_reg, column_pointer_reg}))
		else $error("command taken while busy");
	a_swr_flag: assert property (
		@(posedge clk) disable iff (reset)
		c_swr |=> s_reset_run)
		else $error("reset flag timing wrong");
	a_hw_reset_flag: assert property (
		@(posedge clk) disable iff (reset)
		$fell(reset) |-> s_reset_run)
		else $error("reset flag wrong after hardware reset");
	a_swr_regs: assert property (
		@(posedge clk) disable iff (reset)
		c_swr |=> first_common_row == lcdcd_pkg::LINE_RESET
		&& page_select_reg == lcdcd_pkg::PAGE_RESET)
		else $error("soft reset left registers unchanged");

	// Read path.
	a_status_off: assert property (
		@(posedge clk) disable iff (reset)
		stat_rd |=> data_out[lcdcd_pkg::ST_OFF] == !display_on
		&& data_out[3:0] == 4'h0)
		else $error("status off bit wrong");
	a_status_flags: assert property (
		@(posedge clk) disable iff (reset)
		stat_rd |=> data_out[lcdcd_pkg::ST_BUSY] == $past(busy)
		&& data_out[lcdcd_pkg::ST_RESET] == $past(resetting)
		&& data_out[lcdcd_pkg::ST_ORDER] == !reversed_segment_order)
		else $error("status flags wrong");
	a_read_latch: assert property (
		@(posedge clk) disable iff (reset)
		dat_rd |=> data_out == $past(io_latch_reg))
		else $error("data read did not return the latch");
	a_oe_pulse: assert property (
		@(posedge clk) disable iff (reset)
		stat_rd || dat_rd |=> data_oe)
		else $error("bus not driven after a read");
	a_oe_idle: assert property (
		@(posedge clk) disable iff (reset)
		!(stat_rd || dat_rd) |=> !data_oe)
		else $error("bus driven without an accepted read");
endmodule

//--- verification/lcdcd_host.sv
// Host processor model driving the parallel bus of the decoder.
// Assumes the bench calls access once per transfer, never two at once.
`timescale 1ns/1ps
module lcdcd_host (
	// Clock.
	input wire logic clk,
	// Bus towards the device.
	output logic cmd_data_select,
	output logic rd_strobe,
	output logic wr_strobe,
	output logic [7:0] data_in,
	// Read answer.
	input wire logic [7:0] data_out
);
	initial begin
		cmd_data_select = 1'b0;
		rd_strobe = 1'b0;
		wr_strobe = 1'b0;
		data_in = 8'h00;
	end
	// No busy polling: commands finish on the device's own timing.
	task automatic access(input logic s, r, input logic [7:0] w,
		output logic [7:0] q);
		@(posedge clk);
		#1;
		cmd_data_select = s;
		rd_strobe = r;
		wr_strobe = !r;
		data_in = w;
		@(posedge clk);
		#1;
		rd_strobe = 1'b0;
		wr_strobe = 1'b0;
		// A released bus shows the inverse, so a stale byte never matches.
		data_in = ~w;
		q = data_out;
	endtask
endmodule

//--- verification/test_lcd_command_decoder.sv
// Self-checking bench for the segment LCD command decoder.
// Assumes the host model owns the bus and this module clk and reset.
`timescale 1ns/1ps
module test_lcd_command_decoder;
	logic clk, reset, sel, rd, wr, oe, on, rev, sta, duty, rmw;
	logic [7:0] din, dout, q, b0, b1, v;
	logic [7:0] d [3];
	logic [3:0] m;
	logic [4:0] row;
	int failures, n_checks, seed, j;
	lcdcd_top lcdcd_top_inst (.clk(clk), .reset(reset),
		.cmd_data_select(sel), .rd_strobe(rd), .wr_strobe(wr),
		.data_in(din), .data_out(dout), .data_oe(oe), .display_on(on),
		.first_common_row(row), .reversed_segment_order(rev),
		.static_drive(sta), .duty_32(duty), .rmw_active(rmw));
	lcdcd_host lcdcd_host_inst (.clk(clk), .cmd_data_select(sel),
		.rd_strobe(rd), .wr_strobe(wr), .data_in(din), .data_out(dout));
	task automatic chk(input string nm, input logic [7:0] s, e);
		n_checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmd(input logic [7:0] c);
		lcdcd_host_inst.access(1'b0, 1'b0, c, q);
	endtask
	task automatic wd(input logic [7:0] x);
		lcdcd_host_inst.access(1'b1, 1'b0, x, q);
	endtask
	task automatic rdd(input logic s);
		lcdcd_host_inst.access(s, 1'b1, 8'h00, q);
		chk("data_oe", {7'h00, oe}, 8'h01);
	endtask
	function automatic logic [7:0] st(input logic b, r, o, x);
		return {b, !r, !o, x, 4'h0};
	endfunction
	function automatic logic [7:0] mc(input int k);
		return (k == 0) ? 8'hAE : 8'(8'hA0 + 4 * (k - 1));
	endfunction
	task automatic give_verdict;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#20000;
		failures++;
		give_verdict;
	end
	initial begin
		seed = 32'h7724b21c;
		reset = 1'b1;
		repeat (3) @(posedge clk);
		#1 reset = 1'b0;
		rdd(1'b0);
		chk("status busy", q, st(1'b1, 1'b0, 1'b0, 1'b1));
		cmd(8'hAF);
		chk("refused", {7'h00, on}, 8'h00);
		repeat (4) @(posedge clk);
		rdd(1'b0);
		chk("status idle", q, st(1'b0, 1'b0, 1'b0, 1'b0));
		chk("modes", {3'h0, duty, rev, sta, rmw, on}, 8'h10);
		m = 4'h8;
		for (int i = 0; i < 16; i++) begin
			j = (i < 8) ? i / 2 : ($random(seed) & 3);
			b0 = (i < 8) ? 8'(i % 2) : 8'($random(seed) & 1);
			cmd(mc(j) | b0);
			m[j] = b0[0];
			chk("modes", {4'h0, duty, sta, rev, on}, {4'h0, m});
			rdd(1'b0);
			chk("status", q, st(1'b0, m[1], m[0], 1'b0));
		end
		for (int i = 0; i < 5; i++) begin
			b0 = (i == 0) ? 8'hDF : (8'hC0 | ($random(seed) & 8'h1F));
			cmd(b0);
			chk("start line", {3'h0, row}, b0 & 8'h1F);
		end
		cmd(8'hE8);
		chk("unknown", {row, duty, sta, rev}, {b0[4:0], m[3:1]});
		b1 = $random(seed) & 8'h02;
		v = 8'($unsigned($random(seed)) % 77);
		cmd(8'hB8 | b1);
		cmd(v);
		for (int k = 0; k < 3; k++) begin
			d[k] = $random(seed);
			wd(d[k]);
		end
		cmd(8'hB8 | (b1 ^ 8'h01));
		cmd(v);
		wd(~d[0]);
		chk("page no display", {3'h0, row}, b0 & 8'h1F);
		cmd(8'hB8 | b1);
		cmd(v);
		rdd(1'b1);
		for (int k = 0; k < 3; k++) begin
			rdd(1'b1);
			chk("ram read", q, d[k]);
		end
		b0 = $random(seed);
		cmd(8'h4F);
		wd(b0);
		wd(~b0);
		cmd(8'h4F);
		rdd(1'b1);
		rdd(1'b1);
		chk("last column", q, b0);
		rdd(1'b1);
		rdd(1'b1);
		chk("column stop", q, 8'h00);
		cmd(v);
		cmd(8'hE0);
		chk("rmw on", {7'h00, rmw}, 8'h01);
		rdd(1'b1);
		rdd(1'b1);
		chk("rmw read", q, d[0]);
		b0 = $random(seed);
		wd(b0);
		cmd(8'hEE);
		chk("rmw off", {7'h00, rmw}, 8'h00);
		rdd(1'b1);
		rdd(1'b1);
		chk("rmw restore", q, b0);
		cmd(8'hE2);
		rdd(1'b0);
		chk("soft busy", q, st(1'b1, m[1], m[0], 1'b1));
		wd(8'h5A);
		repeat (5) @(posedge clk);
		chk("soft line", {3'h0, row}, 8'h00);
		b0 = $random(seed);
		cmd(8'h05);
		wd(b0);
		cmd(8'hBB);
		cmd(8'h05);
		rdd(1'b1);
		rdd(1'b1);
		chk("soft page", q, b0);
		give_verdict;
	end
endmodule
